// file: design/ivw_ctrl.sv
`timescale 1ns/1ps
`default_nettype none

module ivw_ctrl (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cen_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [4:0] ext_int_i,
  input wire logic [4:0] timer1_req_i,
  input wire logic [2:0] timer2_req_i,
  input wire logic [8:0] uart1_req_i,
  input wire logic [8:0] uart2_req_i,
  input wire logic [3:0] dma_req_i,
  input wire logic [6:0] usb_hi_req_i,
  input wire logic [14:0] usb_lo_req_i,
  input wire logic [31:0] can_req_i,
  input wire logic [4:0] spi1_req_i,
  input wire logic [4:0] spi2_req_i,
  input wire logic disk_primary_req_i,
  input wire logic rtc_periodic_req_i,
  input wire logic conv_ready_req_i,
  input wire logic timer2_cmp_a_req_i,
  input wire logic timer2_cmp_b_req_i,
  input wire logic watchdog_req_i,
  input wire logic bus_error_i,
  input wire logic pll_lock_i,
  input wire logic ext_clk_i,
  input wire logic uart1_rx_in_i,
  input wire logic uart2_rx_in_i,
  input wire logic spi1_slave_clk_i,
  input wire logic spi2_slave_clk_i,
  input wire logic can_rx_pin_i,
  input wire logic usb_resume_i,
  input wire logic rtc_alarm_i,
  output logic irq_o,
  output logic fast_request_o,
  output logic stop_req_o
);

  ivw_pkg::ivw_bus_e bus_state;
  ivw_pkg::ivw_bus_e next_bus_state;
  logic [31:0] rdata;
  logic [4:0] sel_ch;
  logic sel_found;

  logic [1:0] ctrl;
  logic [2:0] fast_mask;
  logic [2:0] fast_pend;
  logic [31:0] chan_mask;
  logic [31:0] chan_pend;
  logic [15:0] vec_base;
  logic [15:0] wu_wake;
  logic [15:0] wu_edge;
  logic [15:0] wu_pend;
  logic stop_en;
  logic stop_tog;
  logic armed;
  logic [19:0] tab [ivw_pkg::NUM_CH];
  logic [3:0] cur_prio;
  logic [3:0] stack [ivw_pkg::STACK_DEPTH];
  logic [4:0] sp;

  // Wake-up line sources, in line order.
  wire [15:0] wu_src = {rtc_alarm_i, usb_resume_i, 1'b0, can_rx_pin_i,
    spi2_slave_clk_i, spi1_slave_clk_i, uart2_rx_in_i, uart1_rx_in_i,
    ext_clk_i, pll_lock_i, 1'b0, ext_int_i};
  wire [15:0] wu_lvl;
  wire [15:0] wu_evt;

  // Every line is synchronised; only the stop request's asynchronous hit reads the raw wu_src lines.
  genvar g;
  generate
    for (g = 0; g < ivw_pkg::NUM_WL; g++) begin : g_line
      ivw_wake_line #(
        .BOTH_EDGES(g == ivw_pkg::WL_PLL)
      ) u_line (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .cen_i(cen_i),
        .line_i(wu_src[g]),
        .rise_sel_i(wu_edge[g]),
        .level_o(wu_lvl[g]),
        .event_o(wu_evt[g])
      );
    end
  endgenerate

  // Bus decode.
  wire req = wb_cyc_i & wb_stb_i;
  wire acc = req & wb_ack_o;
  wire wr = acc & wb_we_i;
  wire rd = acc & ~wb_we_i;
  wire [31:0] wmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
    {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] wdat = wb_dat_i & wmask;
  wire hit_ctrl = wb_adr_i == ivw_pkg::ADR_CTRL;
  wire hit_prio = wb_adr_i == ivw_pkg::ADR_CUR_PRIO;
  wire hit_vec = wb_adr_i == ivw_pkg::ADR_VECTOR;
  wire hit_fmask = wb_adr_i == ivw_pkg::ADR_FAST_MASK;
  wire hit_fpend = wb_adr_i == ivw_pkg::ADR_FAST_PEND;
  wire hit_cmask = wb_adr_i == ivw_pkg::ADR_CHAN_MASK;
  wire hit_cpend = wb_adr_i == ivw_pkg::ADR_CHAN_PEND;
  wire hit_end = wb_adr_i == ivw_pkg::ADR_END_INT;
  wire hit_wwake = wb_adr_i == ivw_pkg::ADR_WU_WAKE;
  wire hit_wedge = wb_adr_i == ivw_pkg::ADR_WU_EDGE;
  wire hit_wpend = wb_adr_i == ivw_pkg::ADR_WU_PEND;
  wire hit_wctrl = wb_adr_i == ivw_pkg::ADR_WU_CTRL;
  wire hit_tab = wb_adr_i[31:7] == ivw_pkg::ADR_TABLE[31:7];
  wire [4:0] tab_idx =
    wb_adr_i[ivw_pkg::TABLE_IDX_MSB:ivw_pkg::TABLE_IDX_LSB];

  // External pins: plain level interrupt or wake-up pending bit.
  wire [4:0] ext_req = (wu_wake[4:0] & wu_pend[4:0]) |
    (~wu_wake[4:0] & wu_lvl[4:0]);

  // Source funnel onto the 32 channels; unlisted channels stay low.
  logic [31:0] chan_raw;
  always_comb begin
    chan_raw = 32'h0000_0000;
    chan_raw[ivw_pkg::CH_EXT_GRP] = |ext_req[3:0];
    chan_raw[ivw_pkg::CH_EXT4] = ext_req[4];
    chan_raw[ivw_pkg::CH_WAKE] =
      |(wu_pend & ivw_pkg::WL_INTERNAL);
    chan_raw[ivw_pkg::CH_TIMER1] = |timer1_req_i;
    chan_raw[ivw_pkg::CH_TIMER2] = |timer2_req_i;
    chan_raw[ivw_pkg::CH_UART1] = |uart1_req_i;
    chan_raw[ivw_pkg::CH_UART2] = |uart2_req_i;
    chan_raw[ivw_pkg::CH_DMA] = |dma_req_i;
    chan_raw[ivw_pkg::CH_USB_HI] = |usb_hi_req_i;
    chan_raw[ivw_pkg::CH_USB_LO] = |usb_lo_req_i;
    chan_raw[ivw_pkg::CH_CAN] = |can_req_i;
    chan_raw[ivw_pkg::CH_SPI1] = |spi1_req_i;
    chan_raw[ivw_pkg::CH_SPI2] = |spi2_req_i;
    chan_raw[ivw_pkg::CH_DISK] = disk_primary_req_i;
    chan_raw[ivw_pkg::CH_RTC] = rtc_periodic_req_i;
    chan_raw[ivw_pkg::CH_CONV] = conv_ready_req_i;
    chan_raw[ivw_pkg::CH_CMP_A] = timer2_cmp_a_req_i;
    chan_raw[ivw_pkg::CH_CMP_B] = timer2_cmp_b_req_i;
    chan_raw[ivw_pkg::CH_WDG] = watchdog_req_i;
  end

  wire [2:0] fast_raw = {bus_error_i, timer2_cmp_b_req_i,
    chan_raw[ivw_pkg::CH_EXT_GRP]};

  // Pending bits: a set in the clearing cycle wins.
  wire [31:0] chan_clr = (wr & hit_cpend) ? wdat : 32'h0000_0000;
  wire [2:0] fast_clr = (wr & hit_fpend) ? wdat[2:0] : 3'h0;
  wire [15:0] wu_clr = (wr & hit_wpend) ? wdat[15:0] : 16'h0000;
  wire [15:0] wu_set = wu_evt & ivw_pkg::WL_VALID &
    (wu_wake | ivw_pkg::WL_INTERNAL);
  wire [31:0] next_chan_pend = chan_raw | (chan_pend & ~chan_clr);
  wire [2:0] next_fast_pend = fast_raw | (fast_pend & ~fast_clr);
  wire [15:0] next_wu_pend = wu_set | (wu_pend & ~wu_clr);

  // Highest priority above the current level; ties go upward.
  wire [31:0] chan_req = chan_pend & chan_mask;
  logic best_found;
  logic [4:0] best_ch;
  logic [3:0] best_prio;
  always_comb begin
    best_found = 1'b0;
    best_ch = 5'h00;
    best_prio = 4'h0;
    for (int i = 0; i < ivw_pkg::NUM_CH; i++) begin
      if (chan_req[i] && tab[i][3:0] > cur_prio &&
          tab[i][3:0] >= best_prio) begin
        best_found = 1'b1;
        best_ch = 5'(i);
        best_prio = tab[i][3:0];
      end
    end
  end

  assign irq_o = ctrl[ivw_pkg::CTRL_IRQ_EN] & best_found;
  assign fast_request_o = ctrl[ivw_pkg::CTRL_FIQ_EN] &
    |(fast_pend & fast_mask);

  // Stop request: asynchronous hit while armed, made permanent by a toggle.
  wire [15:0] stop_lines = wu_wake & ivw_pkg::WL_STOP_CAPABLE;
  wire async_hit = |(stop_lines & ~(wu_src ^ wu_edge));
  wire sync_hit = |(stop_lines & wu_evt);
  assign stop_req_o = stop_en & (stop_tog ^ (armed & async_hit));

  // Read data selection.
  wire [15:0] vec_entry = best_found ?
    tab[best_ch][19:4] : 16'h0000;
  logic [31:0] rmux;
  always_comb begin
    rmux = 32'h0000_0000;
    if (hit_ctrl) rmux = {30'h0000_0000, ctrl};
    if (hit_prio) rmux = {28'h000_0000, cur_prio};
    if (hit_vec) rmux = {vec_base, vec_entry};
    if (hit_fmask) rmux = {29'h0000_0000, fast_mask};
    if (hit_fpend) rmux = {29'h0000_0000, fast_pend};
    if (hit_cmask) rmux = chan_mask;
    if (hit_cpend) rmux = chan_pend;
    if (hit_wwake) rmux = {16'h0000, wu_wake};
    if (hit_wedge) rmux = {16'h0000, wu_edge};
    if (hit_wpend) rmux = {16'h0000, wu_pend};
    if (hit_wctrl) rmux = {31'h0000_0000, stop_en};
    if (hit_tab) rmux = {tab[tab_idx][19:4], 12'h000, tab[tab_idx][3:0]};
  end

  always_comb begin
    case (bus_state)
      ivw_pkg::BUS_IDLE: next_bus_state = req ? ivw_pkg::BUS_ACK :
        ivw_pkg::BUS_IDLE;
      ivw_pkg::BUS_ACK: next_bus_state = ivw_pkg::BUS_IDLE;
      default: next_bus_state = ivw_pkg::BUS_IDLE;
    endcase
  end

  assign wb_ack_o = bus_state == ivw_pkg::BUS_ACK;
  assign wb_dat_o = rdata;

  wire accept = rd & hit_vec & sel_found & (sp < 5'(ivw_pkg::STACK_DEPTH));
  wire pop = wr & hit_end & (sp != 5'h00);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      bus_state <= ivw_pkg::BUS_IDLE;
      rdata <= 32'h0000_0000;
      sel_ch <= 5'h00;
      sel_found <= 1'b0;
    end else if (cen_i) begin
      bus_state <= next_bus_state;
      if (req && bus_state == ivw_pkg::BUS_IDLE) begin
        rdata <= rmux;
        sel_ch <= best_ch;
        sel_found <= best_found;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl <= ivw_pkg::RST_CTRL;
      fast_mask <= ivw_pkg::RST_FAST_MASK;
      chan_mask <= ivw_pkg::RST_CHAN_MASK;
      vec_base <= ivw_pkg::RST_VEC_BASE;
      wu_wake <= ivw_pkg::RST_WU_WAKE;
      wu_edge <= ivw_pkg::RST_WU_EDGE;
      stop_en <= 1'b0;
    end else if (cen_i && wr) begin
      if (hit_ctrl) ctrl <= (ctrl & ~wmask[1:0]) | wdat[1:0];
      if (hit_fmask) fast_mask <= (fast_mask & ~wmask[2:0]) | wdat[2:0];
      if (hit_cmask) chan_mask <= (chan_mask & ~wmask) | wdat;
      if (hit_vec) vec_base <= (vec_base & ~wmask[31:16]) |
        wdat[31:16];
      if (hit_wwake) wu_wake <= (wu_wake & ~wmask[15:0]) | wdat[15:0];
      if (hit_wedge) wu_edge <= (wu_edge & ~wmask[15:0]) | wdat[15:0];
      if (hit_wctrl && wb_sel_i[0]) stop_en <= wdat[0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < ivw_pkg::NUM_CH; i++) begin
        tab[i] <= ivw_pkg::RST_TABLE;
      end
    end else if (cen_i && wr && hit_tab) begin
      tab[tab_idx] <= {(tab[tab_idx][19:4] & ~wmask[31:16]) | wdat[31:16],
        (tab[tab_idx][3:0] & ~wmask[3:0]) | wdat[3:0]};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_pend <= 32'h0000_0000;
      fast_pend <= 3'h0;
      wu_pend <= 16'h0000;
      stop_tog <= 1'b0;
      armed <= 1'b1;
    end else if (cen_i) begin
      chan_pend <= next_chan_pend;
      fast_pend <= next_fast_pend;
      wu_pend <= next_wu_pend;
      if (armed && sync_hit) begin
        stop_tog <= ~stop_tog;
        armed <= 1'b0;
      end else if (!armed && !(|(wu_pend & stop_lines))) begin
        armed <= 1'b1;
      end
    end
  end

  // Priority nesting stack.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_prio <= 4'h0;
      sp <= 5'h00;
      for (int i = 0; i < ivw_pkg::STACK_DEPTH; i++) begin
        stack[i] <= 4'h0;
      end
    end else if (cen_i) begin
      if (accept) begin
        stack[sp[3:0]] <= cur_prio;
        sp <= sp + 5'h01;
        cur_prio <= tab[sel_ch][3:0];
      end else if (pop) begin
        sp <= sp - 5'h01;
        cur_prio <= stack[4'(sp - 5'h01)];
      end
    end
  end

endmodule

`default_nettype wire

// file: common/ivw_pkg.sv
package ivw_pkg;

  localparam int NUM_CH = 32;
  localparam int NUM_WL = 16;
  localparam int PRIO_W = 4;
  localparam int STACK_DEPTH = 16;
  localparam int SP_W = 5;
  localparam int NUM_FAST = 3;

  // Register byte addresses.
  localparam logic [31:0] ADR_CTRL = 32'hFFFF_FC00;
  localparam logic [31:0] ADR_CUR_PRIO = 32'hFFFF_FC08;
  localparam logic [31:0] ADR_VECTOR = 32'hFFFF_FC18;
  localparam logic [31:0] ADR_FAST_MASK = 32'hFFFF_FC1C;
  localparam logic [31:0] ADR_FAST_PEND = 32'hFFFF_FC20;
  localparam logic [31:0] ADR_CHAN_MASK = 32'hFFFF_FC24;
  localparam logic [31:0] ADR_CHAN_PEND = 32'hFFFF_FC28;
  localparam logic [31:0] ADR_END_INT = 32'hFFFF_FC2C;
  localparam logic [31:0] ADR_WU_WAKE = 32'hFFFF_FC30;
  localparam logic [31:0] ADR_WU_EDGE = 32'hFFFF_FC34;
  localparam logic [31:0] ADR_WU_PEND = 32'hFFFF_FC38;
  localparam logic [31:0] ADR_WU_CTRL = 32'hFFFF_FC3C;
  localparam logic [31:0] ADR_TABLE = 32'hFFFF_FC80;
  localparam int TABLE_IDX_LSB = 2;
  localparam int TABLE_IDX_MSB = 6;

  // Field positions.
  localparam int CTRL_IRQ_EN = 0;
  localparam int CTRL_FIQ_EN = 1;
  localparam int WU_CTRL_STOP_EN = 0;
  localparam int VEC_BASE_LSB = 16;
  localparam int TAB_ENTRY_LSB = 16;
  localparam int FAST_EXT = 0;
  localparam int FAST_CMP_B = 1;
  localparam int FAST_BUS_ERR = 2;

  // Channel numbers.
  localparam int CH_EXT_GRP = 0;
  localparam int CH_EXT4 = 1;
  localparam int CH_WAKE = 2;
  localparam int CH_TIMER1 = 3;
  localparam int CH_TIMER2 = 4;
  localparam int CH_UART1 = 5;
  localparam int CH_UART2 = 6;
  localparam int CH_DMA = 7;
  localparam int CH_USB_HI = 10;
  localparam int CH_USB_LO = 11;
  localparam int CH_CAN = 12;
  localparam int CH_SPI1 = 13;
  localparam int CH_SPI2 = 14;
  localparam int CH_DISK = 15;
  localparam int CH_RTC = 16;
  localparam int CH_CONV = 23;
  localparam int CH_CMP_A = 29;
  localparam int CH_CMP_B = 30;
  localparam int CH_WDG = 31;

  // Wake-up line numbers and line groups.
  localparam int WL_PLL = 6;
  localparam int WL_CLK = 7;
  localparam int WL_UART1 = 8;
  localparam int WL_UART2 = 9;
  localparam int WL_SPI1 = 10;
  localparam int WL_SPI2 = 11;
  localparam int WL_CAN = 12;
  localparam int WL_USB = 14;
  localparam int WL_RTC = 15;
  localparam logic [15:0] WL_VALID = 16'hDFDF;
  localparam logic [15:0] WL_INTERNAL = 16'hDFC0;
  localparam logic [15:0] WL_STOP_CAPABLE = 16'hDF9F;

  // Reset values.
  localparam logic [1:0] RST_CTRL = 2'h0;
  localparam logic [2:0] RST_FAST_MASK = 3'h0;
  localparam logic [31:0] RST_CHAN_MASK = 32'h0000_0000;
  localparam logic [15:0] RST_VEC_BASE = 16'h0000;
  localparam logic [15:0] RST_WU_WAKE = 16'h0000;
  localparam logic [15:0] RST_WU_EDGE = 16'hFFFF;
  localparam logic [19:0] RST_TABLE = 20'h0_0000;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } ivw_bus_e;

endpackage

// file: design/ivw_wake_line.sv
`timescale 1ns/1ps
`default_nettype none

module ivw_wake_line #(
  parameter bit BOTH_EDGES = 1'b0
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cen_i,
  input wire logic line_i,
  input wire logic rise_sel_i,
  output logic level_o,
  output logic event_o
);

  logic meta;
  logic sync;
  logic last;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= 1'b0;
      sync <= 1'b0;
      last <= 1'b0;
    end else if (cen_i) begin
      meta <= line_i;
      sync <= meta;
      last <= sync;
    end
  end

  wire rise = sync & ~last;
  wire fall = ~sync & last;

  assign level_o = sync;
  assign event_o = BOTH_EDGES ? (rise | fall) : (rise_sel_i ? rise : fall);

endmodule

`default_nettype wire

// file: verif/ivw_chk.sv
`timescale 1ns/1ps
`default_nettype none
module ivw_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cen_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic [31:0] wb_dat_o,
  input wire logic irq_o,
  input wire logic fast_request_o,
  input wire logic stop_req_o
);
  logic wrote;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wrote <= 1'b0;
    end else if (wb_ack_o && wb_we_i) begin
      wrote <= 1'b1;
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  ack_next_a: assert property (cen_i && wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("Request not answered next cycle.");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("Ack longer than one cycle.");
  ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
    else $error("Ack without request.");
  ack_idle_a: assert property (!wb_stb_i [*2] |-> !wb_ack_o)
    else $error("Ack while bus idle.");
  reset_quiet_a: assert property (disable iff (1'b0) $fell(rst_i) |-> !wb_ack_o
    && !irq_o && !fast_request_o && !stop_req_o && wb_dat_o == 32'h0000_0000)
    else $error("Outputs not quiet after reset.");
  rdata_hold_a: assert property (!wb_ack_o |-> $stable(wb_dat_o))
    else $error("Read data moved outside an access.");
  irq_gate_a: assert property (irq_o |-> wrote)
    else $error("Request without enabling write.");
  fast_gate_a: assert property (fast_request_o |-> wrote)
    else $error("Fast request without enabling write.");
  stop_gate_a: assert property (stop_req_o |-> wrote)
    else $error("Stop request while disabled.");
  cover property (wb_ack_o && !wb_we_i);
  cover property ($rose(irq_o));
  cover property ($rose(fast_request_o));
  cover property ($rose(stop_req_o));
endmodule
bind ivw_ctrl ivw_chk u_chk (.clk_i(clk_i), .rst_i(rst_i), .cen_i(cen_i),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .irq_o(irq_o),
  .fast_request_o(fast_request_o), .stop_req_o(stop_req_o));
`default_nettype wire

// file: verif/ivw_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module ivw_core_model (
  input wire logic clk_i,
  input wire logic irq_i,
  input wire logic fiq_i,
  input wire logic stop_i,
  output logic [15:0] taken_o,
  output logic clk_on_o
);
  logic req_q = 1'b0;
  logic [15:0] taken = 16'h0000;
  logic clk_on = 1'b0;
  assign taken_o = taken;
  assign clk_on_o = clk_on;
  always @(posedge clk_i) begin
    req_q <= irq_i | fiq_i;
    // A rise of irq or fast request counts as taken only when neither was high the cycle before.
    if ((irq_i | fiq_i) && !req_q) taken <= taken + 16'h0001;
    // Power control restores the main clock on a stop request.
    if (stop_i) clk_on <= 1'b1;
  end
endmodule
`default_nettype wire

// file: verif/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ck_run = 1'b0;
  logic [31:0] adr = '0, wdat = '0, q, rdat, expw;
  logic [105:0] src = '0;
  logic [15:0] wl = '0, taken;
  logic [15:0] ent[32];
  logic ack, irq, fast_request, stop, clk_on;
  int err_total = 0, comparisons = 0, cur, best;
  int lo[32], wd[32], pr[32], stk[$];
  always #4 clk_i = ~clk_i;
  logic ck_line = 1'b0;
  always @(posedge clk_i) ck_line <= ck_run ? ~ck_line : wl[7];
  ivw_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .cen_i(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(q), .wb_ack_o(ack),
    .ext_int_i(src[4:0]), .timer1_req_i(src[9:5]),
    .timer2_req_i(src[12:10]), .uart1_req_i(src[21:13]),
    .uart2_req_i(src[30:22]), .dma_req_i(src[34:31]),
    .usb_hi_req_i(src[41:35]), .usb_lo_req_i(src[56:42]),
    .can_req_i(src[88:57]), .spi1_req_i(src[93:89]),
    .spi2_req_i(src[98:94]), .disk_primary_req_i(src[99]),
    .rtc_periodic_req_i(src[100]), .conv_ready_req_i(src[101]),
    .timer2_cmp_a_req_i(src[102]), .timer2_cmp_b_req_i(src[103]),
    .watchdog_req_i(src[104]), .bus_error_i(src[105]),
    .pll_lock_i(wl[6]), .ext_clk_i(ck_line), .uart1_rx_in_i(wl[8]),
    .uart2_rx_in_i(wl[9]), .spi1_slave_clk_i(wl[10]),
    .spi2_slave_clk_i(wl[11]), .can_rx_pin_i(wl[12]),
    .usb_resume_i(wl[14]), .rtc_alarm_i(wl[15]), .irq_o(irq),
    .fast_request_o(fast_request), .stop_req_o(stop));
  ivw_core_model u_core (.clk_i(clk_i), .irq_i(irq), .fiq_i(fast_request),
    .stop_i(stop), .taken_o(taken), .clk_on_o(clk_on));
  function automatic logic [31:0] pend_exp(input logic [105:0] s);
    logic [31:0] p;
    p = '0;
    for (int c = 0; c < 32; c++) p[c] = |((s >> lo[c]) & ((106'd1 << wd[c]) - 1));
    return p;
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                     input string what);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    rdat = q;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rdat, exp, $sformatf("reg %h", a));
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task automatic results;
    $display("comparisons %0d errors %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk_i);
    err_total++;
    results();
  end
  initial begin
    void'($urandom(32'hd3647792));
    lo = '{0,4,0,5,10,13,22,31,0,0,35,42,57,89,94,99,100,0,0,0,0,0,0,101,
           0,0,0,0,0,102,103,104};
    wd = '{4,1,0,5,3,9,9,4,0,0,7,15,32,5,5,1,1,0,0,0,0,0,0,1,
           0,0,0,0,0,1,1,1};
    tick(3);
    rst_i <= 1'b0;
    tick(1);
    rd(ivw_pkg::ADR_CTRL, 32'h0000_0000);
    rd(ivw_pkg::ADR_CHAN_MASK, 32'h0000_0000);
    rd(ivw_pkg::ADR_WU_EDGE, 32'h0000_FFFF);
    rd(ivw_pkg::ADR_VECTOR, 32'h0000_0000);
    bus(1'b1, 32'hFFFF_FC04, 32'hFFFF_FFFF);
    rd(32'hFFFF_FC04, 32'h0000_0000);
    for (int c = 0; c < 32; c++) begin
      if (wd[c] > 0) begin
        src <= '0;
        tick(6);
        bus(1'b1, ivw_pkg::ADR_CHAN_PEND, 32'hFFFF_FFFF);
        src[lo[c] + ($urandom % wd[c])] <= 1'b1;
        tick(6);
        rd(ivw_pkg::ADR_CHAN_PEND, pend_exp(src));
      end
    end
    src <= '1;
    wl[15] <= 1'b1;
    tick(6);
    rd(ivw_pkg::ADR_CHAN_PEND, 32'hE081_FCFF);
    rd(ivw_pkg::ADR_WU_PEND, 32'h0000_8000);
    bus(1'b1, ivw_pkg::ADR_CHAN_MASK, 32'hFFFF_FFFF);
    bus(1'b1, ivw_pkg::ADR_VECTOR, 32'hA5A5_0000);
    for (int c = 0; c < 32; c++) begin
      ent[c] = 16'($urandom);
      pr[c] = $urandom % 16;
      bus(1'b1, ivw_pkg::ADR_TABLE + 4 * c, {ent[c], 12'h000, pr[c][3:0]});
    end
    bus(1'b1, ivw_pkg::ADR_CTRL, 32'h0000_0001);
    cur = 0;
    repeat (6) begin
      tick(1);
      best = -1;
      for (int c = 0; c < 32; c++)
        if (wd[c] + (c == 2) > 0 && pr[c] > cur && (best < 0 || pr[c] >= pr[best]))
          best = c;
      chk(irq, best >= 0, "irq");
      bus(1'b0, ivw_pkg::ADR_VECTOR, 32'h0000_0000);
      chk(rdat, {16'hA5A5, best < 0 ? 16'h0000 : ent[best]}, "vector");
      if (best >= 0) begin
        stk.push_back(cur);
        cur = pr[best];
      end
      rd(ivw_pkg::ADR_CUR_PRIO, cur);
    end
    repeat (3) begin
      bus(1'b1, ivw_pkg::ADR_END_INT, 32'h0000_0000);
      if (stk.size() > 0) cur = stk.pop_back();
      rd(ivw_pkg::ADR_CUR_PRIO, cur);
    end
    bus(1'b1, ivw_pkg::ADR_CHAN_MASK, 32'h0000_0000);
    tick(1);
    chk(irq, 1'b0, "irq");
    rd(ivw_pkg::ADR_CHAN_PEND, 32'hE081_FCFF);
    bus(1'b1, ivw_pkg::ADR_FAST_MASK, 32'h0000_0007);
    bus(1'b1, ivw_pkg::ADR_CTRL, 32'h0000_0003);
    tick(1);
    chk(fast_request, 1'b1, "fiq");
    rd(ivw_pkg::ADR_FAST_PEND, 32'h0000_0007);
    bus(1'b1, ivw_pkg::ADR_FAST_MASK, 32'h0000_0000);
    tick(1);
    chk(fast_request, 1'b0, "fiq");
    src <= '0;
    wl <= '0;
    tick(6);
    bus(1'b1, ivw_pkg::ADR_FAST_PEND, 32'h0000_0007);
    rd(ivw_pkg::ADR_FAST_PEND, 32'h0000_0000);
    src[103] <= 1'b1;
    bus(1'b1, ivw_pkg::ADR_FAST_MASK, 32'h0000_0002);
    tick(1);
    chk(fast_request, 1'b1, "fiq");
    bus(1'b1, ivw_pkg::ADR_WU_PEND, 32'h0000_FFFF);
    bus(1'b1, ivw_pkg::ADR_WU_WAKE, 32'h0000_FFFF);
    bus(1'b1, ivw_pkg::ADR_WU_CTRL, 32'h0000_0001);
    wl[6] <= 1'b1;
    tick(6);
    rd(ivw_pkg::ADR_WU_PEND, 32'h0000_0040);
    chk(stop, 1'b0, "stop");
    expw = 32'h0000_0040;
    for (int l = 7; l < 16; l++) begin
      if (l != 13) begin
        wl[l] <= 1'b1;
        expw[l] = 1'b1;
        tick(6);
        rd(ivw_pkg::ADR_WU_PEND, expw);
        if (l == 7) chk(stop, 1'b1, "stop");
      end
    end
    ck_run <= 1'b1;
    tick(4);
    bus(1'b1, ivw_pkg::ADR_WU_PEND, 32'h0000_FFFF);
    tick(6);
    rd(ivw_pkg::ADR_WU_PEND, 32'h0000_0080);
    ck_run <= 1'b0;
    bus(1'b1, ivw_pkg::ADR_WU_EDGE, 32'h0000_FEFF);
    tick(6);
    bus(1'b1, ivw_pkg::ADR_WU_PEND, 32'h0000_FFFF);
    wl[8] <= 1'b0;
    tick(6);
    rd(ivw_pkg::ADR_WU_PEND, 32'h0000_0100);
    chk(taken != 0, 1'b1, "taken");
    chk(clk_on, 1'b1, "clock");
    results();
  end
endmodule
`default_nettype wire
